// >>> hw/pin_mux_pkg.sv
// constants shared by the port b / port c alternate-function mux
package pin_mux_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int PIN_W = 16;
  localparam int SRC_W = 12;
  localparam int GROUP_W = 2;
  localparam int FUSE_W = 4;
  // ----------------------------------------------------------------
  // pin positions, port c pins sit at PORT_W + bit
  // ----------------------------------------------------------------
  localparam int PB_SS = 0;
  localparam int PB_CLK = 1;
  localparam int PB_MOSI = 2;
  localparam int PB_MISO = 3;
  localparam int PB_TCLK = 4;
  localparam int PB_CMP = 7;
  localparam int PC_RST = 9;
  localparam int PC_SRC11 = 10;
  localparam int PC_SRC10 = 12;
  localparam int PC_CMP_B = 13;
  localparam int PC_CMP_A = 14;
  localparam int PC_CAP = 15;
  // ----------------------------------------------------------------
  // pin-change groups and fuse vector positions
  // ----------------------------------------------------------------
  localparam int GROUP_B = 0;
  localparam int GROUP_C = 1;
  localparam int FUSE_RST_DIS = 0;
  localparam int FUSE_DBG_EN = 1;
  localparam int FUSE_LOCK_UNPROG = 2;
  localparam int FUSE_CLK_OUT = 3;
  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [FUSE_W-1:0] FUSE_SYNC_RST = 4'hf;
  localparam logic [PIN_W-1:0] PIN_SYNC_RST = 16'h0000;
  localparam logic PAD_PULLUP_RST = 1'b0;
  localparam logic PAD_OE_RST = 1'b0;
  localparam logic PAD_OUT_RST = 1'b0;
  localparam logic PAD_IN_EN_RST = 1'b1;
  localparam logic [PIN_W-1:0] DIN_RST = 16'h0000;
endpackage : pin_mux_pkg

// >>> hw/two_flop_sync.sv
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module two_flop_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // meta_q is read by sync_q only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : two_flop_sync
`default_nettype wire

// >>> hw/pin_override_cell.sv
// one pad's override resolution with registered pad controls
`timescale 1ns/10ps
`default_nettype none
module pin_override_cell (
  input wire logic clk,
  input wire logic rst,
  input wire logic dir_bit,
  input wire logic out_bit,
  input wire logic global_pullup_disable,
  input wire logic sleep_active,
  input wire logic pullup_override_en,
  input wire logic pullup_override_val,
  input wire logic direction_override_en,
  input wire logic direction_override_val,
  input wire logic value_override_en,
  input wire logic value_override_val,
  input wire logic input_en_override_en,
  input wire logic input_en_override_val,
  output logic pad_pullup,
  output logic pad_oe,
  output logic pad_out,
  output logic pad_in_en
);
  logic pullup_d;
  logic oe_d;
  logic out_d;
  logic in_en_d;
  logic pullup_q;
  logic oe_q;
  logic out_q;
  logic in_en_q;

  always_comb begin
    pullup_d = pullup_override_en ? pullup_override_val
             : ({dir_bit, out_bit, global_pullup_disable} == 3'h2); // RULE20
    oe_d = direction_override_en ? direction_override_val : dir_bit; // RULE21
    out_d = value_override_en ? value_override_val : out_bit; // RULE22
    in_en_d = input_en_override_en ? input_en_override_val : !sleep_active; // RULE23
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pullup_q <= pin_mux_pkg::PAD_PULLUP_RST;
      oe_q <= pin_mux_pkg::PAD_OE_RST;
      out_q <= pin_mux_pkg::PAD_OUT_RST;
      in_en_q <= pin_mux_pkg::PAD_IN_EN_RST;
    end else begin
      pullup_q <= pullup_d;
      oe_q <= oe_d;
      out_q <= out_d;
      in_en_q <= in_en_d;
    end
  end

  assign pad_pullup = pullup_q;
  assign pad_oe = oe_q;
  assign pad_out = out_q;
  assign pad_in_en = in_en_q;
endmodule : pin_override_cell
`default_nettype wire

// >>> hw/port_b_c_alternate_function_mux.sv
// alternate-function override mux for two 8-bit general i/o ports
//
// Notes on behaviour
// RULE1 - master forces miso input; slave follows direction
// RULE2 - forced spi inputs keep pull-up from port bit
// RULE3 - slave forces mosi input; master follows direction
// RULE4 - slave forces spi clock input; master drives clock when direction set
// RULE5 - slave forces slave select input
// RULE6 - slave active only while select held low
// RULE7 - miso carries master in/slave out; mosi reverse
// RULE8 - download uses pb3 as programming data out
// RULE9 - download uses pb2 as programming data in
// RULE10 - spi clock pin clocks serial programming
// RULE11 - pb4 feeds 16-bit timer external clock
// RULE12 - twelve distinct pin-change sources, pb0-7, pc2/4/5/6
// RULE13 - pc7 feeds capture and external interrupt 4
// RULE14 - pc7 outputs oscillator clock only by fuse
// RULE15 - pc6 drives compare a when direction set
// RULE16 - pc5 drives compare b when direction set
// RULE17 - pc1 is active-low reset when fuse reads 1 and debug is off
// RULE18 - reset pin: pull-up on, driver, input off
// RULE19 - debug fuse and open locks: open-drain line
// RULE20 - pull-up override, else direction/port/disable 010
// RULE21 - direction override, else direction bit
// RULE22 - value override replaces port bit when driving
// RULE23 - input-enable override, else sleep logic decides
// RULE24 - pin-change mask and group keep input on
// RULE25 - spi overrides only while spi enabled
`timescale 1ns/10ps
`default_nettype none
module port_b_c_alternate_function_mux (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] dir_b,
  input wire logic [7:0] out_b,
  input wire logic [7:0] dir_c,
  input wire logic [7:0] out_c,
  input wire logic global_pullup_disable,
  input wire logic sleep_active,
  input wire logic spi_enable_bit,
  input wire logic spi_master_select,
  input wire logic spi_master_out,
  input wire logic spi_slave_out,
  input wire logic spi_clock_out,
  input wire logic prog_mode,
  input wire logic prog_data_out,
  input wire logic [11:0] pin_change_mask,
  input wire logic [1:0] pin_change_group_enable,
  input wire logic timer8_compare_a_en,
  input wire logic timer8_compare_a_out,
  input wire logic timer16_compare_a_en,
  input wire logic timer16_compare_a_out,
  input wire logic timer16_compare_b_en,
  input wire logic timer16_compare_b_out,
  input wire logic timer16_compare_c_en,
  input wire logic timer16_compare_c_out,
  input wire logic ext_interrupt_4_en,
  input wire logic osc_clock,
  input wire logic debug_drive_low,
  input wire logic reset_disable_fuse,
  input wire logic debug_enable_fuse,
  input wire logic lock_bits_unprog,
  input wire logic clock_out_fuse,
  input wire logic [7:0] pad_in_b,
  input wire logic [7:0] pad_in_c,
  output logic [7:0] pad_pullup_b,
  output logic [7:0] pad_oe_b,
  output logic [7:0] pad_out_b,
  output logic [7:0] pad_in_en_b,
  output logic [7:0] pad_pullup_c,
  output logic [7:0] pad_oe_c,
  output logic [7:0] pad_out_c,
  output logic [7:0] pad_in_en_c,
  output logic spi_master_in,
  output logic spi_slave_in,
  output logic spi_clock_in,
  output logic spi_slave_select_n,
  output logic spi_slave_active,
  output logic prog_data_in,
  output logic prog_clock_in,
  output logic timer16_ext_clock_in,
  output logic timer16_capture_in,
  output logic ext_interrupt_4,
  output logic [11:0] pin_change_source,
  output logic ext_reset_n,
  output logic one_wire_debug_in,
  output logic osc_clock_out
);
  localparam int PW = pin_mux_pkg::PIN_W;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [PW-1:0] pad_sync;
  logic [pin_mux_pkg::FUSE_W-1:0] fuse_sync;
  logic [pin_mux_pkg::FUSE_W-1:0] fuse_raw;

  assign fuse_raw = {clock_out_fuse, lock_bits_unprog, debug_enable_fuse, reset_disable_fuse};

  two_flop_sync #(
    .WIDTH(PW),
    .RST_VAL(pin_mux_pkg::PIN_SYNC_RST)
  ) u_pad_sync (
    .clk(clk),
    .rst(rst),
    .async_in({pad_in_c, pad_in_b}),
    .sync_out(pad_sync)
  );

  // fuses sit still, but they still arrive from outside the domain
  two_flop_sync #(
    .WIDTH(pin_mux_pkg::FUSE_W),
    .RST_VAL(pin_mux_pkg::FUSE_SYNC_RST)
  ) u_fuse_sync (
    .clk(clk),
    .rst(rst),
    .async_in(fuse_raw),
    .sync_out(fuse_sync)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic spi_on;
  logic spi_master_on;
  logic spi_slave_on;
  logic debug_on;
  logic reset_pin_on;
  logic clk_out_on;
  logic [PW-1:0] dir_all;
  logic [PW-1:0] out_all;
  logic [PW-1:0] pc_hold;

  // programming download owns the spi pins over the spi itself
  assign spi_on = spi_enable_bit && !prog_mode; // RULE25
  assign spi_master_on = spi_on && spi_master_select;
  assign spi_slave_on = spi_on && !spi_master_select;
  // fuses read 0 when programmed
  assign debug_on = !fuse_sync[pin_mux_pkg::FUSE_DBG_EN]
                 && fuse_sync[pin_mux_pkg::FUSE_LOCK_UNPROG]; // RULE19
  assign reset_pin_on = !debug_on && fuse_sync[pin_mux_pkg::FUSE_RST_DIS]; // RULE17
  assign clk_out_on = !fuse_sync[pin_mux_pkg::FUSE_CLK_OUT];
  assign dir_all = {dir_c, dir_b};
  assign out_all = {out_c, out_b};

  // pin-change hold of the digital input, group b then group c
  always_comb begin
    pc_hold = '0;
    for (int i = 0; i < pin_mux_pkg::PORT_W; i++) begin
      pc_hold[i] = pin_change_mask[i] && pin_change_group_enable[pin_mux_pkg::GROUP_B]; // RULE24
    end
    pc_hold[pin_mux_pkg::PC_CMP_A] = pin_change_mask[8]
      && pin_change_group_enable[pin_mux_pkg::GROUP_C]; // RULE24
    pc_hold[pin_mux_pkg::PC_CMP_B] = pin_change_mask[9]
      && pin_change_group_enable[pin_mux_pkg::GROUP_C];
    pc_hold[pin_mux_pkg::PC_SRC10] = pin_change_mask[10]
      && pin_change_group_enable[pin_mux_pkg::GROUP_C];
    pc_hold[pin_mux_pkg::PC_SRC11] = pin_change_mask[11]
      && pin_change_group_enable[pin_mux_pkg::GROUP_C];
  end

  // ----------------------------------------------------------------
  // override signal generation
  // ----------------------------------------------------------------
  logic [PW-1:0] pu_ovr_en;
  logic [PW-1:0] pu_ovr_val;
  logic [PW-1:0] dd_ovr_en;
  logic [PW-1:0] dd_ovr_val;
  logic [PW-1:0] pv_ovr_en;
  logic [PW-1:0] pv_ovr_val;
  logic [PW-1:0] ie_ovr_en;
  logic [PW-1:0] ie_ovr_val;
  logic [PW-1:0] force_in;

  always_comb begin
    force_in = '0;
    if (spi_master_on) begin
      force_in[pin_mux_pkg::PB_MISO] = 1'b1; // RULE1
    end
    if (spi_slave_on) begin
      force_in[pin_mux_pkg::PB_MOSI] = 1'b1; // RULE3
      force_in[pin_mux_pkg::PB_CLK] = 1'b1; // RULE4
      force_in[pin_mux_pkg::PB_SS] = 1'b1; // RULE5
    end
    if (prog_mode) begin
      force_in[pin_mux_pkg::PB_MOSI] = 1'b1; // RULE9
      force_in[pin_mux_pkg::PB_CLK] = 1'b1; // RULE10
    end
  end

  always_comb begin
    pu_ovr_en = force_in;
    pu_ovr_val = out_all & ~{PW{global_pullup_disable}} & force_in; // RULE2
    dd_ovr_en = force_in;
    dd_ovr_val = '0;
    pv_ovr_en = '0;
    pv_ovr_val = '0;
    ie_ovr_en = pc_hold;
    ie_ovr_val = pc_hold;
    // spi and download outputs, spi values apply only where the direction bit drives, download forces pb3 to drive
    if (spi_master_on) begin
      pv_ovr_en[pin_mux_pkg::PB_MOSI] = 1'b1; // RULE7
      pv_ovr_val[pin_mux_pkg::PB_MOSI] = spi_master_out;
      pv_ovr_en[pin_mux_pkg::PB_CLK] = 1'b1; // RULE4
      pv_ovr_val[pin_mux_pkg::PB_CLK] = spi_clock_out;
    end
    if (spi_slave_on) begin
      pv_ovr_en[pin_mux_pkg::PB_MISO] = 1'b1; // RULE7
      pv_ovr_val[pin_mux_pkg::PB_MISO] = spi_slave_out;
    end
    if (prog_mode) begin
      dd_ovr_en[pin_mux_pkg::PB_MISO] = 1'b1; // RULE8
      dd_ovr_val[pin_mux_pkg::PB_MISO] = 1'b1;
      pv_ovr_en[pin_mux_pkg::PB_MISO] = 1'b1;
      pv_ovr_val[pin_mux_pkg::PB_MISO] = prog_data_out;
    end
    // timer compare outputs
    pv_ovr_en[pin_mux_pkg::PB_CMP] = timer8_compare_a_en || timer16_compare_c_en;
    pv_ovr_val[pin_mux_pkg::PB_CMP] = timer8_compare_a_en ? timer8_compare_a_out
                                                          : timer16_compare_c_out;
    pv_ovr_en[pin_mux_pkg::PC_CMP_A] = timer16_compare_a_en; // RULE15
    pv_ovr_val[pin_mux_pkg::PC_CMP_A] = timer16_compare_a_out;
    pv_ovr_en[pin_mux_pkg::PC_CMP_B] = timer16_compare_b_en; // RULE16
    pv_ovr_val[pin_mux_pkg::PC_CMP_B] = timer16_compare_b_out;
    // capture / interrupt 4 input and clock output
    ie_ovr_en[pin_mux_pkg::PC_CAP] = ext_interrupt_4_en; // RULE13
    ie_ovr_val[pin_mux_pkg::PC_CAP] = ext_interrupt_4_en;
    if (clk_out_on) begin
      dd_ovr_en[pin_mux_pkg::PC_CAP] = 1'b1; // RULE14
      dd_ovr_val[pin_mux_pkg::PC_CAP] = 1'b1;
      pv_ovr_en[pin_mux_pkg::PC_CAP] = 1'b1;
      pv_ovr_val[pin_mux_pkg::PC_CAP] = osc_clock;
    end
    // reset / one-wire debug pin
    if (debug_on) begin
      pu_ovr_en[pin_mux_pkg::PC_RST] = 1'b1; // RULE19
      pu_ovr_val[pin_mux_pkg::PC_RST] = 1'b1;
      dd_ovr_en[pin_mux_pkg::PC_RST] = 1'b1;
      dd_ovr_val[pin_mux_pkg::PC_RST] = debug_drive_low;
      pv_ovr_en[pin_mux_pkg::PC_RST] = 1'b1;
      pv_ovr_val[pin_mux_pkg::PC_RST] = 1'b0;
      ie_ovr_en[pin_mux_pkg::PC_RST] = 1'b1;
      ie_ovr_val[pin_mux_pkg::PC_RST] = 1'b1;
    end else if (reset_pin_on) begin
      pu_ovr_en[pin_mux_pkg::PC_RST] = 1'b1; // RULE18
      pu_ovr_val[pin_mux_pkg::PC_RST] = 1'b1;
      dd_ovr_en[pin_mux_pkg::PC_RST] = 1'b1;
      dd_ovr_val[pin_mux_pkg::PC_RST] = 1'b0;
      ie_ovr_en[pin_mux_pkg::PC_RST] = 1'b1;
      ie_ovr_val[pin_mux_pkg::PC_RST] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per-pin resolution
  // ----------------------------------------------------------------
  logic [PW-1:0] pullup_all;
  logic [PW-1:0] oe_all;
  logic [PW-1:0] pout_all;
  logic [PW-1:0] in_en_all;

  for (genvar g = 0; g < PW; g++) begin : g_pin
    pin_override_cell u_cell (
      .clk(clk),
      .rst(rst),
      .dir_bit(dir_all[g]),
      .out_bit(out_all[g]),
      .global_pullup_disable(global_pullup_disable),
      .sleep_active(sleep_active),
      .pullup_override_en(pu_ovr_en[g]),
      .pullup_override_val(pu_ovr_val[g]),
      .direction_override_en(dd_ovr_en[g]),
      .direction_override_val(dd_ovr_val[g]),
      .value_override_en(pv_ovr_en[g]),
      .value_override_val(pv_ovr_val[g]),
      .input_en_override_en(ie_ovr_en[g]),
      .input_en_override_val(ie_ovr_val[g]),
      .pad_pullup(pullup_all[g]),
      .pad_oe(oe_all[g]),
      .pad_out(pout_all[g]),
      .pad_in_en(in_en_all[g])
    );
  end

  assign pad_pullup_b = pullup_all[7:0];
  assign pad_oe_b = oe_all[7:0];
  assign pad_out_b = pout_all[7:0];
  assign pad_in_en_b = in_en_all[7:0];
  assign pad_pullup_c = pullup_all[15:8];
  assign pad_oe_c = oe_all[15:8];
  assign pad_out_c = pout_all[15:8];
  assign pad_in_en_c = in_en_all[15:8];

  // ----------------------------------------------------------------
  // digital inputs to peripherals
  // ----------------------------------------------------------------
  // a disabled input reads low so a floating pad never toggles logic
  logic [PW-1:0] din_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      din_q <= pin_mux_pkg::DIN_RST;
    end else begin
      din_q <= pad_sync & in_en_all;
    end
  end

  assign spi_master_in = din_q[pin_mux_pkg::PB_MISO]; // RULE7
  assign spi_slave_in = din_q[pin_mux_pkg::PB_MOSI];
  assign spi_clock_in = din_q[pin_mux_pkg::PB_CLK];
  assign spi_slave_select_n = din_q[pin_mux_pkg::PB_SS];
  assign spi_slave_active = spi_slave_on && !din_q[pin_mux_pkg::PB_SS]; // RULE6
  assign prog_data_in = din_q[pin_mux_pkg::PB_MOSI]; // RULE9
  assign prog_clock_in = din_q[pin_mux_pkg::PB_CLK]; // RULE10
  assign timer16_ext_clock_in = din_q[pin_mux_pkg::PB_TCLK]; // RULE11
  assign timer16_capture_in = din_q[pin_mux_pkg::PC_CAP]; // RULE13
  assign ext_interrupt_4 = din_q[pin_mux_pkg::PC_CAP];
  assign pin_change_source = {din_q[pin_mux_pkg::PC_SRC11], din_q[pin_mux_pkg::PC_SRC10],
                              din_q[pin_mux_pkg::PC_CMP_B], din_q[pin_mux_pkg::PC_CMP_A],
                              din_q[7:0]}; // RULE12
  // the reset input itself is off, so reset reads the synchronised pad
  assign ext_reset_n = reset_pin_on ? pad_sync[pin_mux_pkg::PC_RST] : 1'b1; // RULE17
  assign one_wire_debug_in = debug_on ? din_q[pin_mux_pkg::PC_RST] : 1'b1; // RULE19
  assign osc_clock_out = pout_all[pin_mux_pkg::PC_CAP] && oe_all[pin_mux_pkg::PC_CAP];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_MISO_MASTER_IN: assert property (@(posedge clk) disable iff (rst) // RULE1
    spi_master_on |=> !pad_oe_b[3] && pad_pullup_b[3] == $past(out_b[3] && !global_pullup_disable))
    else $error("miso not forced to input in master mode");

  AST_MISO_SLAVE_OUT: assert property (@(posedge clk) disable iff (rst) // RULE7
    spi_slave_on && !prog_mode |=> pad_oe_b[3] == $past(dir_b[3])
      && (!pad_oe_b[3] || pad_out_b[3] == $past(spi_slave_out)))
    else $error("miso does not carry slave output");

  AST_SLAVE_FORCED_IN: assert property (@(posedge clk) disable iff (rst) // RULE3
    spi_slave_on |=> pad_oe_b[2:0] == 3'h0)
    else $error("slave mode spi pins not forced to input");

  AST_FORCED_PULLUP: assert property (@(posedge clk) disable iff (rst) // RULE2
    spi_slave_on |=> pad_pullup_b[0] == $past(out_b[0] && !global_pullup_disable))
    else $error("forced input pull-up not from port bit");

  AST_MASTER_CLOCK: assert property (@(posedge clk) disable iff (rst) // RULE4
    spi_master_on && dir_b[1] |=> pad_oe_b[1] && pad_out_b[1] == $past(spi_clock_out))
    else $error("spi clock not driven in master mode");

  AST_SLAVE_ACTIVE: assert property (@(posedge clk) disable iff (rst) // RULE6
    spi_slave_active |-> !spi_slave_select_n && spi_enable_bit && !spi_master_select)
    else $error("slave active without select low");

  AST_PROG_DATA_OUT: assert property (@(posedge clk) disable iff (rst) // RULE8
    prog_mode |=> pad_oe_b[3] && pad_out_b[3] == $past(prog_data_out) && !pad_oe_b[2])
    else $error("programming data pins wrong");

  AST_CMP_A_DIR: assert property (@(posedge clk) disable iff (rst) // RULE15
    timer16_compare_a_en |=> pad_oe_c[6] == $past(dir_c[6])
      && (!pad_oe_c[6] || pad_out_c[6] == $past(timer16_compare_a_out)))
    else $error("compare a output not gated by direction");

  AST_RESET_PIN: assert property (@(posedge clk) disable iff (rst) // RULE18
    reset_pin_on |=> pad_pullup_c[1] && !pad_oe_c[1] && !pad_in_en_c[1])
    else $error("reset pin pad controls wrong");

  AST_DEBUG_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst) // RULE19
    debug_on |=> pad_pullup_c[1] && !pad_out_c[1] && pad_oe_c[1] == $past(debug_drive_low))
    else $error("debug pin not open-drain");

  AST_PLAIN_PULLUP: assert property (@(posedge clk) disable iff (rst) // RULE20
    1'b1 |=> pad_pullup_b[5] == $past(!dir_b[5] && out_b[5] && !global_pullup_disable))
    else $error("plain pull-up decode wrong");

  AST_PIN_CHANGE_SOURCE_KEEPS_INPUT: assert property (@(posedge clk) disable iff (rst) // RULE24
    pin_change_mask[4] && pin_change_group_enable[0] |=> pad_in_en_b[4])
    else $error("pin-change input disabled");
endmodule : port_b_c_alternate_function_mux
`default_nettype wire

// >>> tb/pad_partner.sv
// pad-side model of spi peers, serial programmer and debug emulator
`timescale 1ns/10ps
`default_nettype none
module pad_partner (
  input wire logic clk,
  input wire logic [15:0] pu_en,
  input wire logic [15:0] oe,
  input wire logic [15:0] out,
  input wire logic [15:0] drv_en,
  input wire logic [15:0] drv_val,
  output logic [15:0] pad
);
  logic [15:0] last_q = 16'h0000;
  // plain always: the initial level above needs a second writer
  always @(posedge clk) begin
    last_q <= pad;
  end
  // device driver wins, so an open-drain low beats the emulator
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (oe[i]) begin
        pad[i] = out[i];
      end else if (drv_en[i]) begin
        pad[i] = drv_val[i];
      end else if (pu_en[i]) begin
        pad[i] = 1'h1;
      end else begin
        pad[i] = ~last_q[i]; // floating: never trust a stale level
      end
    end
  end
endmodule : pad_partner
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the port b / port c alternate-function mux
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] dir_b = 8'h00, out_b = 8'h00, dir_c = 8'h00, out_c = 8'h00;
  logic gpd = 1'h0, slp = 1'h0, spen = 1'h0, msel = 1'h0, smo = 1'h0, sso = 1'h0;
  logic sco = 1'h0, prog = 1'h0, pgo = 1'h0, t8e = 1'h0, t8o = 1'h0, tae = 1'h0;
  logic tao = 1'h0, tbe = 1'h0, tbo = 1'h0, tce = 1'h0, tco = 1'h0, i4e = 1'h0;
  logic osc = 1'h0, dbl = 1'h0, rdf = 1'h1, def = 1'h1, lku = 1'h1, cof = 1'h1;
  logic [11:0] msk = 12'h000;
  logic [1:0] grp = 2'h0;
  logic [15:0] drv_en = 16'h0000, drv_val = 16'h0000, pad;
  logic [7:0] pu_b, oe_b, po_b, ie_b, pu_c, oe_c, po_c, ie_c;
  logic mi, si, ci, ssn, act, pgi, pci, tck, cap, i4, rstn, dwi, cko;
  logic [11:0] pcs;
  int bad_count = 0;
  int compares = 0;
  int pos[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 14, 13, 12, 10};
  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  port_b_c_alternate_function_mux port_b_c_alternate_function_mux_i (
    .clk(clk), .rst(rst), .dir_b(dir_b), .out_b(out_b), .dir_c(dir_c), .out_c(out_c),
    .global_pullup_disable(gpd), .sleep_active(slp), .spi_enable_bit(spen),
    .spi_master_select(msel), .spi_master_out(smo), .spi_slave_out(sso),
    .spi_clock_out(sco), .prog_mode(prog), .prog_data_out(pgo), .pin_change_mask(msk),
    .pin_change_group_enable(grp), .timer8_compare_a_en(t8e), .timer8_compare_a_out(t8o),
    .timer16_compare_a_en(tae), .timer16_compare_a_out(tao), .timer16_compare_b_en(tbe),
    .timer16_compare_b_out(tbo), .timer16_compare_c_en(tce), .timer16_compare_c_out(tco),
    .ext_interrupt_4_en(i4e), .osc_clock(osc), .debug_drive_low(dbl),
    .reset_disable_fuse(rdf), .debug_enable_fuse(def), .lock_bits_unprog(lku),
    .clock_out_fuse(cof), .pad_in_b(pad[7:0]), .pad_in_c(pad[15:8]),
    .pad_pullup_b(pu_b), .pad_oe_b(oe_b), .pad_out_b(po_b), .pad_in_en_b(ie_b),
    .pad_pullup_c(pu_c), .pad_oe_c(oe_c), .pad_out_c(po_c), .pad_in_en_c(ie_c),
    .spi_master_in(mi), .spi_slave_in(si), .spi_clock_in(ci), .spi_slave_select_n(ssn),
    .spi_slave_active(act), .prog_data_in(pgi), .prog_clock_in(pci),
    .timer16_ext_clock_in(tck), .timer16_capture_in(cap), .ext_interrupt_4(i4),
    .pin_change_source(pcs), .ext_reset_n(rstn), .one_wire_debug_in(dwi),
    .osc_clock_out(cko));
  pad_partner pad_partner_i (
    .clk(clk), .pu_en({pu_c, pu_b}), .oe({oe_c, oe_b}), .out({po_c, po_b}),
    .drv_en(drv_en), .drv_val(drv_val), .pad(pad));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // covers the 3-edge synchroniser path with margin
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task automatic tally_and_finish();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200us;
    bad_count++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    settle();
    chk({oe_b, oe_c}, 16'h0000);
    chk(ie_b, 8'hff);
    @(posedge clk);
    out_b <= 8'hf0;
    settle();
    chk(pu_b, 8'hf0);
    @(posedge clk);
    gpd <= 1'h1;
    settle();
    chk(pu_b, 8'h00);
    @(posedge clk);
    {gpd, spen, msel, smo, sco, dir_b, out_b} <= {5'h0f, 8'h0f, 8'h08};
    {drv_en, drv_val} <= {16'h0008, 16'h0008};
    settle();
    chk(oe_b, 8'h07);
    chk(pu_b, 8'h08);
    chk({po_b[2:1], mi}, 3'h7);
    @(posedge clk);
    {msel, sso, out_b} <= {2'h1, 8'h07};
    {drv_en, drv_val} <= {16'h0007, 16'h0006};
    settle();
    chk(oe_b, 8'h08);
    chk(pu_b, 8'h07);
    chk({po_b[3], si, ci, act, ssn}, 5'h1e);
    @(posedge clk);
    drv_val <= 16'h0007;
    settle();
    chk({act, ssn}, 2'h1);
    @(posedge clk);
    {spen, prog, pgo} <= 3'h3;
    settle();
    chk({oe_b[3], po_b[3], pgi, pci}, 4'hf);
    @(posedge clk);
    {prog, pgo, dir_b, out_b} <= {2'h0, 16'h0000};
    drv_en <= 16'hffff;
    for (int i = 0; i < 12; i++) begin
      drv_val <= 16'h0001 << pos[i];
      settle();
      chk(pcs, 12'h001 << i);
      chk(tck, i == 4);
      @(posedge clk);
    end
    drv_val <= 16'h8000;
    settle();
    chk({cap, i4, rstn}, 3'h6);
    @(posedge clk);
    {slp, msk, grp} <= {13'h1010, 2'h1};
    i4e <= 1'h1;
    settle();
    chk(ie_b, 8'h10);
    chk({pu_c[1], oe_c[1], ie_c[1], ie_c[7]}, 4'h9);
    @(posedge clk);
    {slp, grp, tae, tao, tbe, tbo} <= 7'h0f;
    settle();
    chk(oe_c[6:5], 2'h0);
    @(posedge clk);
    dir_c <= 8'h60;
    settle();
    chk({oe_c[6:5], po_c[6:5]}, 4'hf);
    // pb7: timer8 compare a wins over timer16 compare c
    @(posedge clk);
    {dir_b, t8e, t8o, tce, tco} <= {8'h80, 4'he};
    settle();
    chk({oe_b[7], po_b[7]}, 2'h3);
    @(posedge clk);
    t8e <= 1'h0;
    settle();
    chk(po_b[7], 1'h0);
    @(posedge clk);
    {cof, osc} <= 2'h1;
    settle();
    chk({oe_c[7], cko}, 2'h3);
    @(posedge clk);
    {cof, def, dbl} <= 3'h5;
    settle();
    chk({oe_c[7], pu_c[1], oe_c[1], po_c[1], dwi}, 5'h0c);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
